// *** spp_pkg.sv ***
package spp_pkg;

  // instruction first bytes
  localparam logic [7:0] CMD_ENABLE     = 8'hac;
  localparam logic [7:0] CMD_RD_PROG    = 8'h20;
  localparam logic [7:0] CMD_LD_PAGE    = 8'h40;
  localparam logic [7:0] CMD_WR_PAGE    = 8'h4c;
  localparam logic [7:0] CMD_RD_EE      = 8'ha0;
  localparam logic [7:0] CMD_WR_EE      = 8'hc0;
  localparam logic [7:0] CMD_RD_LOCK_HF = 8'h58;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h50;
  localparam logic [7:0] CMD_RD_SIG     = 8'h30;
  localparam logic [7:0] CMD_RD_CAL     = 8'h38;
  localparam logic [7:0] HSEL_MASK      = 8'hf7;
  localparam int         HSEL_BIT       = 3;

  // second-byte qualifiers
  localparam logic [7:0] EN_SECOND      = 8'h53;
  localparam logic [2:0] SUB_ERASE      = 3'h4;
  localparam logic [2:0] SUB_WR_LOCK    = 3'h7;
  localparam logic [7:0] SUB_WR_FUSE_L  = 8'ha0;
  localparam logic [7:0] SUB_WR_FUSE_H  = 8'ha8;
  localparam logic [7:0] SUB_RD_LOCK    = 8'h00;
  localparam logic [7:0] SUB_RD_FUSE_H  = 8'h08;
  localparam logic [7:0] SUB_RD_FUSE_L  = 8'h00;

  // framing
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [1:0] IDX_B2         = 2'h1;
  localparam logic [1:0] IDX_B3         = 2'h2;
  localparam logic [1:0] IDX_B4         = 2'h3;

  // memory geometry
  localparam int FLASH_WORDS = 8192;
  localparam int FLASH_AW    = 13;
  localparam int PAGE_WORDS  = 64;
  localparam int PAGE_AW     = 6;
  localparam int PAGE_NUM_W  = 7;
  localparam int EE_BYTES    = 512;
  localparam int EE_AW       = 9;
  localparam logic [FLASH_AW-1:0] ERASE_LAST = 13'h1fff;
  localparam logic [FLASH_AW-1:0] PAGE_LAST  = 13'h003f;

  // reset and erased values
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [5:0]  LOCK_RST    = 6'h3f;
  localparam logic [7:0]  FUSE_L_RST  = 8'hff;
  localparam logic [7:0]  FUSE_H_RST  = 8'hff;
  // identity bytes: values are arbitrary
  localparam logic [7:0]  SIG_BYTE0   = 8'h5a;
  localparam logic [7:0]  SIG_BYTE1   = 8'h01;
  localparam logic [7:0]  SIG_BYTE2   = 8'h02;
  localparam logic [7:0]  CAL_BYTE    = 8'h80;

  // self-timed programming durations
  localparam real CLK_PERIOD_NS           = 4.0;
  localparam real FLASH_PAGE_WAIT_MIN_MS  = 4.5;
  localparam real EEPROM_BYTE_WAIT_MIN_MS = 9.0;
  localparam real CHIP_ERASE_WAIT_MIN_MS  = 9.0;
  localparam int  FLASH_PAGE_WAIT_CYC  = int'($ceil(FLASH_PAGE_WAIT_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  EEPROM_BYTE_WAIT_CYC = int'($ceil(EEPROM_BYTE_WAIT_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  CHIP_ERASE_WAIT_CYC  = int'($ceil(CHIP_ERASE_WAIT_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  BUSY_W               = 22;

  typedef enum logic [1:0] {BUSY_NONE, BUSY_FLASH, BUSY_EEPROM, BUSY_ERASE} busy_e;

endpackage

// *** spi_frame_if.sv ***
`timescale 1ns/1ps
interface spi_frame_if;
  logic        active;
  logic        byte_done;
  logic [1:0]  byte_idx;
  logic [7:0]  rx_byte;
  logic        frame_done;
  logic [31:0] frame;
  logic [7:0]  tx_byte;

  modport link (input active, input tx_byte, output byte_done, output byte_idx, output rx_byte,
                output frame_done, output frame);
  modport core (output active, output tx_byte, input byte_done, input byte_idx, input rx_byte,
                input frame_done, input frame);
endinterface

// *** spi_bit_link.sv ***
`timescale 1ns/1ps
module spi_bit_link (
  input  wire logic    clk,   // core clock
  input  wire logic    rstn,  // async reset, active low
  input  wire logic    sck,   // serial clock pin
  input  wire logic    mosi,  // serial data in pin
  output logic         miso,  // serial data out pin
  spi_frame_if.link    fr     // framed bytes to the decoder
);
  logic        sck_s1_r, sck_s2_r, sck_d_r;
  logic        mosi_s1_r, mosi_s2_r;
  logic [2:0]  bit_cnt_r;
  logic [1:0]  byte_cnt_r;
  logic [31:0] shift_r;
  logic [7:0]  tx_r;
  logic        miso_r;
  logic        byte_done_r, frame_done_r;
  logic [1:0]  byte_idx_r;
  logic        rise, fall;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_s1_r  <= 1'b0;
      sck_s2_r  <= 1'b0;
      sck_d_r   <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
    end else begin
      sck_s1_r  <= sck;
      sck_s2_r  <= sck_s1_r;
      sck_d_r   <= sck_s2_r;
      mosi_s1_r <= mosi;
      mosi_s2_r <= mosi_s1_r;
    end
  end

  assign rise = sck_s2_r & ~sck_d_r;
  assign fall = ~sck_s2_r & sck_d_r;

  // counters restart whenever the device leaves programming reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r  <= '0;
      byte_cnt_r <= '0;
      shift_r    <= '0;
    end else if (!fr.active) begin
      bit_cnt_r  <= '0;
      byte_cnt_r <= '0;
    end else if (rise) begin
      shift_r   <= {shift_r[30:0], mosi_s2_r};
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == spp_pkg::LAST_BIT) begin
        byte_cnt_r <= byte_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      byte_done_r  <= 1'b0;
      frame_done_r <= 1'b0;
      byte_idx_r   <= '0;
    end else begin
      byte_done_r  <= fr.active & rise & (bit_cnt_r == spp_pkg::LAST_BIT);
      frame_done_r <= fr.active & rise & (bit_cnt_r == spp_pkg::LAST_BIT) & (byte_cnt_r == spp_pkg::IDX_B4);
      byte_idx_r   <= byte_cnt_r;
    end
  end

  // reply byte is taken right after a byte ends, before the next falling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_r   <= '0;
      miso_r <= 1'b0;
    end else if (!fr.active) begin
      tx_r   <= '0;
      miso_r <= 1'b0;
    end else if (byte_done_r) begin
      tx_r <= fr.tx_byte;
    end else if (fall) begin
      miso_r <= tx_r[7];
      tx_r   <= {tx_r[6:0], 1'b0};
    end
  end

  assign miso          = miso_r;
  assign fr.byte_done  = byte_done_r;
  assign fr.frame_done = frame_done_r;
  assign fr.byte_idx   = byte_idx_r;
  assign fr.rx_byte    = shift_r[7:0];
  assign fr.frame      = shift_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  rx_sample_rise_a: assert property (fr.active && rise |=> shift_r[0] == $past(mosi_s2_r))
    else $error("input bit not taken on serial clock rise");
  tx_shift_fall_a: assert property (fr.active && fall && !byte_done_r |=> miso == $past(tx_r[7]))
    else $error("output bit not driven on serial clock fall");
endmodule

// *** serial_program_cmd_decoder.sv ***
`timescale 1ns/1ps
module serial_program_cmd_decoder #(
  parameter logic [spp_pkg::BUSY_W-1:0] FLASH_BUSY_CYC = spp_pkg::BUSY_W'(spp_pkg::FLASH_PAGE_WAIT_CYC),
  parameter logic [spp_pkg::BUSY_W-1:0] EE_BUSY_CYC    = spp_pkg::BUSY_W'(spp_pkg::EEPROM_BYTE_WAIT_CYC),
  parameter logic [spp_pkg::BUSY_W-1:0] ERASE_BUSY_CYC = spp_pkg::BUSY_W'(spp_pkg::CHIP_ERASE_WAIT_CYC)
) (
  input  wire logic clk,         // core clock
  input  wire logic rstn,        // async reset, active low
  input  wire logic reset_pin_n, // device reset pin, low selects serial programming
  input  wire logic sck,         // serial clock from programmer
  input  wire logic mosi,        // serial data in
  output logic      miso,        // serial data out
  output logic      prog_mode    // programming enabled
);
  spi_frame_if fr ();

  logic                            rp_s1_r, rp_s2_r;
  logic                            prog_en_r;
  spp_pkg::busy_e                  busy_st_r;
  logic [spp_pkg::BUSY_W-1:0]      busy_cnt_r;
  logic [spp_pkg::FLASH_AW-1:0]    sweep_r;
  logic [spp_pkg::FLASH_AW-1:0]    sweep_lim;
  logic [spp_pkg::PAGE_NUM_W-1:0]  busy_page_r;
  logic [spp_pkg::EE_AW-1:0]       ee_pend_addr_r;
  logic [7:0]                      ee_pend_data_r;
  logic                            ee_written_r;
  logic [5:0]                      lock_r;
  logic [7:0]                      fuse_l_r, fuse_h_r;
  logic [7:0]                      tx_byte;
  logic [15:0]                     flash_mem [spp_pkg::FLASH_WORDS];
  logic [15:0]                     page_buf  [spp_pkg::PAGE_WORDS];
  logic [7:0]                      ee_mem    [spp_pkg::EE_BYTES];

  logic [7:0] b1, b2, b3, b4;        // whole frame at frame_done
  logic [7:0] r1, r2, r3;            // first three bytes at the end of byte three
  logic       exec, idle_exec;
  logic       is_enable, is_erase, is_wr_lock, is_wr_fl, is_wr_fh, is_ld_page, is_wr_page, is_wr_ee;

  function automatic logic [spp_pkg::EE_AW-1:0] ee_addr(input logic [7:0] hi, input logic [7:0] lo);
    ee_addr = {hi[0], lo};
  endfunction

  function automatic logic [spp_pkg::FLASH_AW-1:0] fl_addr(input logic [7:0] hi, input logic [7:0] lo);
    fl_addr = {hi[4:0], lo};
  endfunction

  function automatic logic [7:0] sig_byte(input logic [1:0] sel);
    case (sel)
      2'h0:    sig_byte = spp_pkg::SIG_BYTE0;
      2'h1:    sig_byte = spp_pkg::SIG_BYTE1;
      2'h2:    sig_byte = spp_pkg::SIG_BYTE2;
      default: sig_byte = spp_pkg::ERASED_BYTE;
    endcase
  endfunction

  spi_bit_link u_link (
    .clk  (clk),
    .rstn (rstn),
    .sck  (sck),
    .mosi (mosi),
    .miso (miso),
    .fr   (fr.link)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rp_s1_r <= 1'b1;
      rp_s2_r <= 1'b1;
    end else begin
      rp_s1_r <= reset_pin_n;
      rp_s2_r <= rp_s1_r;
    end
  end

  assign fr.active = ~rp_s2_r;
  assign fr.tx_byte = tx_byte;
  assign prog_mode = prog_en_r;

  assign b1 = fr.frame[31:24];
  assign b2 = fr.frame[23:16];
  assign b3 = fr.frame[15:8];
  assign b4 = fr.frame[7:0];
  assign r1 = fr.frame[23:16];
  assign r2 = fr.frame[15:8];
  assign r3 = fr.frame[7:0];

  assign is_enable  = (b1 == spp_pkg::CMD_ENABLE) && (b2 == spp_pkg::EN_SECOND);
  assign is_erase   = (b1 == spp_pkg::CMD_ENABLE) && (b2[7:5] == spp_pkg::SUB_ERASE);
  assign is_wr_lock = (b1 == spp_pkg::CMD_ENABLE) && (b2[7:5] == spp_pkg::SUB_WR_LOCK);
  assign is_wr_fl   = (b1 == spp_pkg::CMD_ENABLE) && (b2 == spp_pkg::SUB_WR_FUSE_L);
  assign is_wr_fh   = (b1 == spp_pkg::CMD_ENABLE) && (b2 == spp_pkg::SUB_WR_FUSE_H);
  assign is_ld_page = (b1 & spp_pkg::HSEL_MASK) == spp_pkg::CMD_LD_PAGE;
  assign is_wr_page = b1 == spp_pkg::CMD_WR_PAGE;
  assign is_wr_ee   = b1 == spp_pkg::CMD_WR_EE;

  // nothing is executed before the whole 32-bit frame is in
  assign exec      = fr.frame_done & prog_en_r;
  // writes during a self-timed cycle are dropped rather than corrupting it
  assign idle_exec = exec & (busy_st_r == spp_pkg::BUSY_NONE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prog_en_r <= 1'b0;
    end else if (!fr.active) begin
      prog_en_r <= 1'b0;
    end else if (fr.frame_done && is_enable) begin
      prog_en_r <= 1'b1;
    end
  end

  // reply byte: echo of the byte just received, read data for the fourth byte
  always_comb begin
    logic [15:0] word;
    word    = flash_mem[fl_addr(r2, r3)];
    tx_byte = 8'h00;
    if (fr.byte_idx != spp_pkg::IDX_B3) begin
      tx_byte = fr.rx_byte;
    end else if (prog_en_r) begin
      if ((r1 & spp_pkg::HSEL_MASK) == spp_pkg::CMD_RD_PROG) begin
        if (busy_st_r == spp_pkg::BUSY_ERASE ||
            (busy_st_r == spp_pkg::BUSY_FLASH && r2[4:0] == busy_page_r[6:2] && r3[7:6] == busy_page_r[1:0])) begin
          tx_byte = spp_pkg::ERASED_BYTE;
        end else begin
          tx_byte = r1[spp_pkg::HSEL_BIT] ? word[15:8] : word[7:0];
        end
      end else if (r1 == spp_pkg::CMD_RD_EE) begin
        if (busy_st_r == spp_pkg::BUSY_ERASE ||
            (busy_st_r == spp_pkg::BUSY_EEPROM && ee_addr(r2, r3) == ee_pend_addr_r)) begin
          tx_byte = spp_pkg::ERASED_BYTE;
        end else begin
          tx_byte = ee_mem[ee_addr(r2, r3)];
        end
      end else if (r1 == spp_pkg::CMD_RD_LOCK_HF && r2 == spp_pkg::SUB_RD_LOCK) begin
        tx_byte = {2'b00, lock_r};
      end else if (r1 == spp_pkg::CMD_RD_LOCK_HF && r2 == spp_pkg::SUB_RD_FUSE_H) begin
        tx_byte = fuse_h_r;
      end else if (r1 == spp_pkg::CMD_RD_FUSE && r2 == spp_pkg::SUB_RD_FUSE_L) begin
        tx_byte = fuse_l_r;
      end else if (r1 == spp_pkg::CMD_RD_SIG) begin
        tx_byte = sig_byte(r3[1:0]);
      end else if (r1 == spp_pkg::CMD_RD_CAL) begin
        tx_byte = spp_pkg::CAL_BYTE;
      end
    end
  end

  always_comb begin
    case (busy_st_r)
      spp_pkg::BUSY_ERASE: sweep_lim = spp_pkg::ERASE_LAST;
      spp_pkg::BUSY_FLASH: sweep_lim = spp_pkg::PAGE_LAST;
      default:             sweep_lim = '0;
    endcase
  end

  // self-timed cycles; the sweep walks memory one word a clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_st_r   <= spp_pkg::BUSY_NONE;
      busy_cnt_r  <= '0;
      sweep_r     <= '0;
      busy_page_r <= '0;
    end else begin
      case (busy_st_r)
        spp_pkg::BUSY_NONE: begin
          sweep_r <= '0;
          if (idle_exec && is_erase) begin
            busy_st_r  <= spp_pkg::BUSY_ERASE;
            busy_cnt_r <= ERASE_BUSY_CYC;
          end else if (idle_exec && is_wr_page) begin
            busy_st_r   <= spp_pkg::BUSY_FLASH;
            busy_cnt_r  <= FLASH_BUSY_CYC;
            busy_page_r <= {b2[4:0], b3[7:6]};
          end else if (idle_exec && is_wr_ee) begin
            busy_st_r  <= spp_pkg::BUSY_EEPROM;
            busy_cnt_r <= EE_BUSY_CYC;
          end
        end
        spp_pkg::BUSY_FLASH, spp_pkg::BUSY_EEPROM, spp_pkg::BUSY_ERASE: begin
          if (busy_cnt_r != '0) begin
            busy_cnt_r <= busy_cnt_r - 1'b1;
          end
          if (sweep_r != sweep_lim) begin
            sweep_r <= sweep_r + 1'b1;
          end
          if (busy_cnt_r == '0 && sweep_r == sweep_lim) begin
            busy_st_r <= spp_pkg::BUSY_NONE;
          end
        end
        default: busy_st_r <= spp_pkg::BUSY_NONE;
      endcase
    end
  end

  // memories carry no reset: contents survive a core reset like real cells
  always_ff @(posedge clk) begin
    if (idle_exec && is_ld_page) begin
      if (b1[spp_pkg::HSEL_BIT]) begin
        page_buf[b3[5:0]][15:8] <= b4;
      end else begin
        page_buf[b3[5:0]][7:0] <= b4;
      end
    end
    if (busy_st_r == spp_pkg::BUSY_FLASH) begin
      flash_mem[{busy_page_r, sweep_r[spp_pkg::PAGE_AW-1:0]}] <= page_buf[sweep_r[spp_pkg::PAGE_AW-1:0]];
    end else if (busy_st_r == spp_pkg::BUSY_ERASE) begin
      flash_mem[sweep_r] <= spp_pkg::ERASED_WORD;
    end
  end

  always_ff @(posedge clk) begin
    if (busy_st_r == spp_pkg::BUSY_ERASE) begin
      ee_mem[sweep_r[spp_pkg::EE_AW-1:0]] <= spp_pkg::ERASED_BYTE;
    end else if (idle_exec && is_wr_ee) begin
      ee_mem[ee_addr(b2, b3)] <= b4;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ee_pend_addr_r <= '0;
      ee_pend_data_r <= '0;
      ee_written_r   <= 1'b0;
    end else if (idle_exec && is_erase) begin
      ee_written_r <= 1'b0;
    end else if (idle_exec && is_wr_ee) begin
      ee_pend_addr_r <= ee_addr(b2, b3);
      ee_pend_data_r <= b4;
      ee_written_r   <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_r   <= spp_pkg::LOCK_RST;
      fuse_l_r <= spp_pkg::FUSE_L_RST;
      fuse_h_r <= spp_pkg::FUSE_H_RST;
    end else if (idle_exec) begin
      if (is_erase) begin
        lock_r <= spp_pkg::LOCK_RST;
      end else if (is_wr_lock) begin
        lock_r <= lock_r & b4[5:0];
      end else if (is_wr_fl) begin
        fuse_l_r <= b4;
      end else if (is_wr_fh) begin
        fuse_h_r <= b4;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  ee_poll_busy_a: assert property (
    fr.byte_done && fr.byte_idx == spp_pkg::IDX_B3 && prog_en_r && r1 == spp_pkg::CMD_RD_EE &&
    busy_st_r == spp_pkg::BUSY_EEPROM && ee_addr(r2, r3) == ee_pend_addr_r |-> tx_byte == spp_pkg::ERASED_BYTE)
    else $error("busy EEPROM location did not read as ff");
  ee_poll_done_a: assert property (
    fr.byte_done && fr.byte_idx == spp_pkg::IDX_B3 && prog_en_r && r1 == spp_pkg::CMD_RD_EE && ee_written_r &&
    busy_st_r == spp_pkg::BUSY_NONE && ee_addr(r2, r3) == ee_pend_addr_r |-> tx_byte == ee_pend_data_r)
    else $error("finished EEPROM write did not read back");
  enable_sets_mode_a: assert property (
    fr.active && fr.frame_done && is_enable |=> prog_en_r)
    else $error("enable instruction did not enter programming");
  mode_hold_a: assert property (
    fr.active && !fr.frame_done |=> $stable(prog_en_r))
    else $error("programming mode changed without a frame");
  echo_second_a: assert property (
    fr.byte_done && fr.byte_idx == spp_pkg::IDX_B2 |-> tx_byte == fr.rx_byte)
    else $error("second byte not echoed");
  lock_read_a: assert property (
    fr.byte_done && fr.byte_idx == spp_pkg::IDX_B3 && prog_en_r && r1 == spp_pkg::CMD_RD_LOCK_HF &&
    r2 == spp_pkg::SUB_RD_LOCK |-> tx_byte == {2'b00, lock_r})
    else $error("lock read returned wrong value");
  lock_write_a: assert property (
    idle_exec && is_wr_lock |=> lock_r == ($past(lock_r) & $past(b4[5:0])))
    else $error("lock write did not program zero bits");
  ee_write_busy_a: assert property (
    idle_exec && is_wr_ee |=> busy_st_r == spp_pkg::BUSY_EEPROM ##1 busy_st_r == spp_pkg::BUSY_EEPROM)
    else $error("EEPROM write did not start a self-timed cycle");
endmodule

// *** isp_prog_model.sv ***
`timescale 1ns/1ps
module isp_prog_model (
  input  wire logic clk,  // core clock, paces the serial clock
  output logic      sck,  // serial clock to the device
  output logic      mosi, // serial data to the device
  input  wire logic miso  // serial data from the device
);
  initial begin
    sck  = 1'b0; // clock stands low between frames
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // all four bytes always go out, whatever came back
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      tick(2);
      mosi = cmd[i]; // set while low, taken on the rise
      tick(2);
      sck = 1'b1; // both phases four core clocks, 32 ns period
      tick(3);
      rsp[i] = miso; // late in the high phase, after the fall shift settled
      tick(1);
      sck = 1'b0;
    end
    mosi = ~cmd[0]; // idle line never shows the last bit
  endtask
endmodule

// *** serial_program_cmd_decoder_tb.sv ***
`timescale 1ns/1ps
module serial_program_cmd_decoder_tb;
  logic        clk;
  logic        rstn;
  logic        reset_pin_n;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        prog_mode;
  logic [31:0] rsp;
  logic [7:0]  ee[int];
  logic [7:0]  fl[int];
  logic [7:0]  lock_m;
  logic [7:0]  sig_m[4];
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          seed         = 32'h842f;

  serial_program_cmd_decoder #(.FLASH_BUSY_CYC(22'h000190), .EE_BUSY_CYC(22'h000190),
                               .ERASE_BUSY_CYC(22'h000190)) dut_u (
    .clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n), .sck(sck), .mosi(mosi),
    .miso(miso), .prog_mode(prog_mode));
  isp_prog_model prog_u (.clk(clk), .sck(sck), .mosi(mosi), .miso(miso));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // bench-side idle time, so the partner model's pacing task is not driven with constants
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is roughly 19k clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rd(input logic [31:0] c, input string nm, input logic [7:0] exp);
    prog_u.xfer(c, rsp);
    chk(nm, exp, rsp[7:0]);
  endtask

  function automatic logic [7:0] eev(input int x);
    return ee.exists(x) ? ee[x] : 8'hff;
  endfunction

  initial begin
    logic [7:0]  d;
    logic [8:0]  a;
    logic [6:0]  p;
    logic [12:0] w;
    rstn = 1'b0;
    reset_pin_n = 1'b1;
    sig_m = '{spp_pkg::SIG_BYTE0, spp_pkg::SIG_BYTE1, spp_pkg::SIG_BYTE2, 8'hff};
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    wait_clk(2);
    reset_pin_n = 1'b0;
    wait_clk(8);
    rd(32'h30000000, "sig_disabled", 8'h00);
    chk("prog_mode_off", 8'h00, {7'h00, prog_mode});
    prog_u.xfer(32'hac530000 | ($random(seed) & 16'hffff), rsp);
    chk("enable_echo", 8'h53, rsp[15:8]);
    wait_clk(4);
    chk("prog_mode_on", 8'h01, {7'h00, prog_mode});
    prog_u.xfer({8'hac, 3'b100, 5'($random(seed)), 16'h0000}, rsp);
    wait_clk(9000); // fixed wait after chip erase
    lock_m = 8'h3f;
    a = 9'($random(seed));
    // erased cells already read ff, so ff writes may be skipped
    rd({8'ha0, 7'h00, a, 8'h00}, "erased_ee", 8'hff);
    for (int k = 0; k < 4; k++) begin
      if (k != 2) a = 9'($random(seed)); // third pass rewrites in place
      d = (k == 3) ? 8'hff : 8'($random(seed) & 8'hfe);
      prog_u.xfer({8'hc0, 7'h00, a, d}, rsp);
      ee[a] = d;
      if (k == 3) begin
        wait_clk(420); // an ff rewrite cannot be polled
        rd({8'ha0, 7'h00, a, 8'h00}, "ee_ff_rewrite", 8'hff);
      end else begin
        rd({8'ha0, 7'h00, a, 8'h00}, "ee_busy", 8'hff);
        rd({8'ha0, 7'h00, a, 8'h00}, "ee_done", eev(a));
      end
    end
    p = 7'($random(seed));
    for (int o = 0; o < 64; o += 63) begin
      for (int h = 0; h < 2; h++) begin
        d = 8'($random(seed));
        fl[{p, 6'(o)} * 2 + h] = d;
        prog_u.xfer({8'h40 | 8'(h << 3), 8'h00, 2'b00, 6'(o), d}, rsp);
      end
    end
    prog_u.xfer({8'h4c, 3'b000, p[6:2], p[1:0], 6'($random(seed)), 8'h00}, rsp);
    w = {p, 6'h00};
    rd({8'h20, 3'b000, w[12:8], w[7:0], 8'h00}, "flash_busy", 8'hff);
    wait_clk(420); // page write time passed without polling
    for (int o = 0; o < 64; o += 63) begin
      for (int h = 0; h < 2; h++) begin
        w = {p, 6'(o)};
        rd({8'h20 | 8'(h << 3), 3'b000, w[12:8], w[7:0], 8'h00}, "flash_word", fl[w * 2 + h]);
      end
    end
    for (int h = 0; h < 2; h++) begin
      d = 8'($random(seed));
      prog_u.xfer({8'hac, (h == 1) ? 8'ha8 : 8'ha0, 8'h00, d}, rsp);
      rd((h == 1) ? 32'h58080000 : 32'h50000000, "fuse", d);
    end
    for (int s = 0; s < 4; s++) begin
      rd({8'h30, 8'h00, 6'h00, 2'(s), 8'h00}, "signature", sig_m[s]);
    end
    rd(32'h38000000, "calibration", spp_pkg::CAL_BYTE);
    d = 8'($random(seed));
    prog_u.xfer({8'hac, 3'b111, 5'h00, 8'h00, 2'b11, d[5:0]}, rsp);
    lock_m = lock_m & {2'b00, d[5:0]};
    rd(32'h58000000, "lock", lock_m);
    reset_pin_n = 1'b1;
    wait_clk(6);
    chk("prog_mode_exit", 8'h00, {7'h00, prog_mode});
    stop_test();
  end
endmodule
